// ### pmicd_pkg.sv
// Constants for the diagnostic and configuration register slice.
package pmicd_pkg;
    localparam logic [7:0] ADDR_MONITOR_MASKS = 8'h2D;
    localparam logic [7:0] ADDR_LOAD_SELECT = 8'h2E;
    localparam logic [7:0] ADDR_LOAD_HIGH = 8'h2F;
    localparam logic [7:0] ADDR_LOAD_LOW = 8'h30;
    localparam logic [7:0] ADDR_FREQ_REPORT = 8'h31;
    localparam logic [7:0] ADDR_BOOST_LIMIT = 8'h32;
    localparam logic [7:0] ADDR_OTP_STATUS = 8'h33;
    localparam logic [7:0] ADDR_UNLOCK_CODE = 8'h34;
    localparam logic [7:0] ADDR_PIN_DISABLE_CTRL = 8'h35;

    // Monitor mask bit positions.
    localparam int MON2_INVALID_BIT = 5;
    localparam int MON2_VALID_BIT = 4;
    localparam int MON1_INVALID_BIT = 3;
    localparam int MON1_VALID_BIT = 2;
    localparam int ANA_INVALID_BIT = 1;
    localparam int ANA_VALID_BIT = 0;
    localparam int MASK_WIDTH = 6;

    localparam int STEP_UP_FREQ_BIT = 2;
    localparam int DOUBLE_ERROR_BIT = 1;
    localparam int SINGLE_ERROR_BIT = 0;
    localparam int ALLOW_LOCKED_BIT = 1;
    localparam int ALLOW_BIT = 0;
    localparam int LOAD_WIDTH = 9;

    localparam logic [7:0] UNLOCK_FIRST = 8'h87;
    localparam logic [7:0] UNLOCK_SECOND = 8'h65;
    localparam logic [7:0] UNLOCK_THIRD = 8'h1B;

    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [5:0] MASK_RESET = 6'h00;
    localparam logic [1:0] SELECT_RESET = 2'h0;
    localparam logic [8:0] LOAD_RESET = 9'h000;
    localparam logic [1:0] LIMIT_RESET = 2'h0;
    localparam logic [1:0] BUCK_FREQ_RESET = 2'h0;

    // One-hot unlock sequence states.
    typedef enum logic [3:0] {
        PMICD_LOCKED = 4'b0001,
        PMICD_GOT_FIRST = 4'b0010,
        PMICD_GOT_SECOND = 4'b0100,
        PMICD_OPEN = 4'b1000
    } pmicd_unlock_t;
endpackage

// ### pmicd_unlock.sv
// Three-write unlock sequencer for the watchdog pin-disable control bit.
`timescale 1ns/1ps
`default_nettype none
module pmicd_unlock (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic code_wr_i,
    input wire logic [7:0] code_i,
    input wire logic watchdog_config_lock_i,
    output logic unlocked_o
);
    pmicd_pkg::pmicd_unlock_t state_r;
    pmicd_pkg::pmicd_unlock_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        if (watchdog_config_lock_i) begin
            state_nxt = pmicd_pkg::PMICD_LOCKED; // [R16] [R18]
        end else if (code_wr_i) begin
            unique case (state_r)
                pmicd_pkg::PMICD_LOCKED: begin
                    state_nxt = (code_i == pmicd_pkg::UNLOCK_FIRST) ? pmicd_pkg::PMICD_GOT_FIRST
                                                                    : pmicd_pkg::PMICD_LOCKED; // [R15]
                end
                pmicd_pkg::PMICD_GOT_FIRST: begin
                    state_nxt = (code_i == pmicd_pkg::UNLOCK_SECOND) ? pmicd_pkg::PMICD_GOT_SECOND
                                                                     : pmicd_pkg::PMICD_LOCKED; // [R15] [R16]
                end
                pmicd_pkg::PMICD_GOT_SECOND: begin
                    state_nxt = (code_i == pmicd_pkg::UNLOCK_THIRD) ? pmicd_pkg::PMICD_OPEN
                                                                    : pmicd_pkg::PMICD_LOCKED; // [R15] [R16]
                end
                pmicd_pkg::PMICD_OPEN: begin
                    // Any further code write closes the lock again.
                    state_nxt = pmicd_pkg::PMICD_LOCKED; // [R16]
                end
                default: begin
                    state_nxt = pmicd_pkg::PMICD_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= pmicd_pkg::PMICD_LOCKED; // [R20]
        end else begin
            state_r <= state_nxt;
        end
    end

    assign unlocked_o = (state_r == pmicd_pkg::PMICD_OPEN);
endmodule
`default_nettype wire

// ### pmicd_regs.sv
// Diagnostic masks, load-current measurement, frequency report, boost limit, OTP status and pin-disable unlock.
// Summary of operation
// R1: Set mask bit suppresses its edge interrupt.
// R2: Masks never alter live power-good status.
// R3: Monitor one: bit3 invalid, bit2 valid.
// R4: Analog supply: bit1 invalid, bit0 valid.
// R5: Masks, frequencies, limit load from OTP.
// R6: Select codes 0,2 buck0; 1,3 buck1.
// R7: Writing select register starts a measurement.
// R8: Nine-bit result, MSB in high register bit0.
// R9: Low register holds eight LSBs, 20 mA/count.
// R10: Bit2 reports boost frequency, 2 or 4 MHz.
// R11: Two-bit buck frequency code, read only.
// R12: Two-bit boost current limit, four steps.
// R13: Status bit1 flags uncorrectable double error.
// R14: Status bit0 flags corrected single error.
// R15: Codes 87h, 65h, 1Bh in order unlock.
// R16: Wrong code or config lock relocks.
// R17: Unlock code register always reads zero.
// R18: No unlocking while config lock set.
// R19: Allow bit settable only when fully unlocked; here the OTP load also sets it while locked.
// R20: Lock status reads one after reset.
// R21: Result bytes update together on completion.
`timescale 1ns/1ps
`default_nettype none
module pmicd_regs (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic otp_load_i,
    input wire logic [5:0] otp_monitor_masks_i,
    input wire logic otp_step_up_freq_code_i,
    input wire logic [1:0] otp_step_down_freq_code_i,
    input wire logic [1:0] otp_step_up_current_limit_i,
    input wire logic otp_pin_disable_allow_i,
    input wire logic otp_single_error_i,
    input wire logic otp_double_error_i,
    input wire logic [5:0] monitor_edge_event_i,
    output logic [5:0] monitor_irq_set_o,
    output logic [5:0] monitor_irq_masks_o,
    output logic meas_start_o,
    output logic meas_buck1_sel_o,
    input wire logic meas_done_i,
    input wire logic [8:0] meas_result_i,
    output logic step_up_freq_code_o,
    output logic [1:0] step_down_freq_code_o,
    output logic [1:0] step_up_current_limit_o,
    input wire logic watchdog_config_lock_i,
    output logic pin_disable_allow_o,
    output logic pin_disable_allow_locked_o
);
    logic [5:0] mask_r;
    logic [1:0] select_r;
    logic [8:0] load_r;
    logic step_up_freq_r;
    logic [1:0] step_down_freq_r;
    logic [1:0] limit_r;
    logic single_error_r;
    logic double_error_r;
    logic allow_r;
    logic start_r;
    logic [7:0] rdata_r;
    logic unlocked;
    logic wr_mask;
    logic wr_select;
    logic wr_limit;
    logic wr_code;
    logic wr_allow;

    assign wr_mask = reg_wr_i && (reg_addr_i == pmicd_pkg::ADDR_MONITOR_MASKS);
    assign wr_select = reg_wr_i && (reg_addr_i == pmicd_pkg::ADDR_LOAD_SELECT);
    assign wr_limit = reg_wr_i && (reg_addr_i == pmicd_pkg::ADDR_BOOST_LIMIT);
    assign wr_code = reg_wr_i && (reg_addr_i == pmicd_pkg::ADDR_UNLOCK_CODE);
    assign wr_allow = reg_wr_i && (reg_addr_i == pmicd_pkg::ADDR_PIN_DISABLE_CTRL);

    pmicd_unlock u_unlock (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .code_wr_i(wr_code),
        .code_i(reg_wdata_i),
        .watchdog_config_lock_i(watchdog_config_lock_i),
        .unlocked_o(unlocked)
    );

    // Interrupt masks; defaults arrive with the OTP load strobe.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mask_r <= pmicd_pkg::MASK_RESET;
        end else if (otp_load_i) begin
            mask_r <= otp_monitor_masks_i; // [R5]
        end else if (wr_mask) begin
            mask_r <= reg_wdata_i[pmicd_pkg::MASK_WIDTH-1:0]; // [R3] [R4]
        end
    end

    // Edge events pass only when unmasked; status paths never see the mask.
    assign monitor_irq_set_o = monitor_edge_event_i & ~mask_r; // [R1] [R2]
    assign monitor_irq_masks_o = mask_r;

    // Measurement select: every write starts a conversion.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            select_r <= pmicd_pkg::SELECT_RESET;
            start_r <= 1'b0;
        end else begin
            start_r <= wr_select; // [R7]
            if (wr_select) begin
                select_r <= reg_wdata_i[1:0];
            end
        end
    end

    assign meas_start_o = start_r;
    assign meas_buck1_sel_o = select_r[0]; // [R6]

    // Both result bytes come from one nine-bit register written at once.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            load_r <= pmicd_pkg::LOAD_RESET;
        end else if (meas_done_i) begin
            load_r <= meas_result_i; // [R21]
        end
    end

    // Frequency report and boost limit.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            step_up_freq_r <= 1'b0;
            step_down_freq_r <= pmicd_pkg::BUCK_FREQ_RESET;
            limit_r <= pmicd_pkg::LIMIT_RESET;
        end else if (otp_load_i) begin
            step_up_freq_r <= otp_step_up_freq_code_i; // [R5] [R10]
            step_down_freq_r <= otp_step_down_freq_code_i; // [R5] [R11]
            limit_r <= otp_step_up_current_limit_i; // [R5]
        end else if (wr_limit) begin
            limit_r <= reg_wdata_i[1:0]; // [R12]
        end
    end

    assign step_up_freq_code_o = step_up_freq_r;
    assign step_down_freq_code_o = step_down_freq_r;
    assign step_up_current_limit_o = limit_r;

    // OTP error-correction flags follow the OTP controller.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            single_error_r <= 1'b0;
            double_error_r <= 1'b0;
        end else begin
            single_error_r <= otp_single_error_i; // [R14]
            double_error_r <= otp_double_error_i; // [R13]
        end
    end

    // Pin-disable allow bit: a written one is taken only when both locks are open; OTP load sets it regardless.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            allow_r <= 1'b0;
        end else if (otp_load_i) begin
            allow_r <= otp_pin_disable_allow_i; // [R5]
        end else if (wr_allow) begin
            if (!reg_wdata_i[pmicd_pkg::ALLOW_BIT]) begin
                allow_r <= 1'b0;
            end else if (unlocked && !watchdog_config_lock_i) begin
                allow_r <= 1'b1; // [R19]
            end
        end
    end

    assign pin_disable_allow_o = allow_r;
    assign pin_disable_allow_locked_o = ~unlocked; // [R20]

    // Read data is registered one cycle after the read strobe.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_r <= pmicd_pkg::READ_ZERO;
        end else if (reg_rd_i) begin
            rdata_r <= pmicd_pkg::READ_ZERO;
            unique case (reg_addr_i)
                pmicd_pkg::ADDR_MONITOR_MASKS: begin
                    rdata_r[pmicd_pkg::MASK_WIDTH-1:0] <= mask_r;
                end
                pmicd_pkg::ADDR_LOAD_SELECT: begin
                    rdata_r[1:0] <= select_r;
                end
                pmicd_pkg::ADDR_LOAD_HIGH: begin
                    rdata_r[0] <= load_r[pmicd_pkg::LOAD_WIDTH-1]; // [R8]
                end
                pmicd_pkg::ADDR_LOAD_LOW: begin
                    rdata_r <= load_r[7:0]; // [R9]
                end
                pmicd_pkg::ADDR_FREQ_REPORT: begin
                    rdata_r[pmicd_pkg::STEP_UP_FREQ_BIT] <= step_up_freq_r; // [R10]
                    rdata_r[1:0] <= step_down_freq_r; // [R11]
                end
                pmicd_pkg::ADDR_BOOST_LIMIT: begin
                    rdata_r[1:0] <= limit_r; // [R12]
                end
                pmicd_pkg::ADDR_OTP_STATUS: begin
                    rdata_r[pmicd_pkg::DOUBLE_ERROR_BIT] <= double_error_r; // [R13]
                    rdata_r[pmicd_pkg::SINGLE_ERROR_BIT] <= single_error_r; // [R14]
                end
                pmicd_pkg::ADDR_UNLOCK_CODE: begin
                    rdata_r <= pmicd_pkg::READ_ZERO; // [R17]
                end
                pmicd_pkg::ADDR_PIN_DISABLE_CTRL: begin
                    rdata_r[pmicd_pkg::ALLOW_LOCKED_BIT] <= ~unlocked; // [R20]
                    rdata_r[pmicd_pkg::ALLOW_BIT] <= allow_r;
                end
                default: begin
                    rdata_r <= pmicd_pkg::READ_ZERO;
                end
            endcase
        end
    end

    assign reg_rdata_o = rdata_r;
endmodule
`default_nettype wire

// ### pmicd_regs_props.sv
// Assertions on the ports of the register slice.
`timescale 1ns/1ps
`default_nettype none
module pmicd_regs_props (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic otp_load_i,
    input wire logic [5:0] monitor_edge_event_i,
    input wire logic [5:0] monitor_irq_set_o,
    input wire logic [5:0] monitor_irq_masks_o,
    input wire logic meas_start_o,
    input wire logic meas_buck1_sel_o,
    input wire logic meas_done_i,
    input wire logic [8:0] meas_result_i,
    input wire logic watchdog_config_lock_i,
    input wire logic pin_disable_allow_o,
    input wire logic pin_disable_allow_locked_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    logic [8:0] last_r;
    wire logic sel_wr = reg_wr_i && reg_addr_i == pmicd_pkg::ADDR_LOAD_SELECT;
    wire logic rd_at = reg_rd_i && !meas_done_i;
    // Mirrors the last finished measurement to judge the result reads.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            last_r <= 9'h000;
        end else if (meas_done_i) begin
            last_r <= meas_result_i;
        end
    end
    a_irq_mask_gate: assert property (
        monitor_irq_set_o == (monitor_edge_event_i & ~monitor_irq_masks_o)) else $error("irq gating wrong");
    a_sel_starts_meas: assert property (sel_wr |=> meas_start_o) else $error("no start");
    a_start_has_cause: assert property (meas_start_o |-> $past(sel_wr)) else $error("stray start");
    a_sel_picks_buck: assert property (
        sel_wr |=> meas_buck1_sel_o == $past(reg_wdata_i[0])) else $error("wrong buck");
    a_code_reads_zero: assert property (
        reg_rd_i && reg_addr_i == pmicd_pkg::ADDR_UNLOCK_CODE |=> reg_rdata_o == 8'h00) else $error("code read");
    a_cfg_lock_closes: assert property (
        watchdog_config_lock_i |=> pin_disable_allow_locked_o) else $error("open under lock");
    a_code_relocks: assert property (
        reg_wr_i && reg_addr_i == pmicd_pkg::ADDR_UNLOCK_CODE && !pin_disable_allow_locked_o
        |=> pin_disable_allow_locked_o) else $error("no relock");
    a_allow_guarded: assert property (
        !otp_load_i && !pin_disable_allow_o && pin_disable_allow_locked_o |=> !pin_disable_allow_o)
        else $error("allow set while locked");
    a_low_byte_pair: assert property (
        rd_at && reg_addr_i == pmicd_pkg::ADDR_LOAD_LOW |=> reg_rdata_o == $past(last_r[7:0]))
        else $error("low byte");
    a_high_bit_pair: assert property (
        rd_at && reg_addr_i == pmicd_pkg::ADDR_LOAD_HIGH |=> reg_rdata_o == {7'h00, $past(last_r[8])})
        else $error("high byte");
    c_meas: cover property (meas_start_o);
    c_unlock: cover property ($fell(pin_disable_allow_locked_o));
    c_irq: cover property (|monitor_irq_set_o);
endmodule
bind pmicd_regs pmicd_regs_props u_props (.*);
`default_nettype wire

// ### pmicd_meas_model.sv
// Behavioural load-current front end that answers measurement starts.
`timescale 1ns/1ps
`default_nettype none
module pmicd_meas_model #(
    parameter int DELAY = 4,
    parameter logic [8:0] RES0 = 9'h0a5,
    parameter logic [8:0] RES1 = 9'h1f4
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic buck1_i,
    output logic done_o,
    output logic [8:0] result_o
);
    int cnt;
    logic [8:0] val;
    // Outside the done pulse the result bus shows the inverse, so a late sample is caught.
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            val <= 9'h000;
            done_o <= 1'b0;
            result_o <= 9'h1ff;
        end else begin
            done_o <= cnt == 1;
            result_o <= (cnt == 1) ? val : ~val;
            if (start_i) begin
                cnt <= DELAY;
                val <= buck1_i ? RES1 : RES0;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### test_pmicd_regs.sv
// Self-checking bench for the diagnostic register slice.
`timescale 1ns/1ps
`default_nettype none
module test_pmicd_regs;
    localparam logic [8:0] RES0 = 9'h0a5;
    localparam logic [8:0] RES1 = 9'h1f4;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic w_en = 1'b0;
    logic r_en = 1'b0;
    logic otp_ld = 1'b0;
    logic [5:0] otp_mask = 6'h00;
    logic [1:0] otp_fd = 2'h0;
    logic otp_fu = 1'b0;
    logic otp_single = 1'b0;
    logic otp_double = 1'b0;
    logic [5:0] ev = 6'h00;
    logic cfg_lock = 1'b0;
    logic done, start, b1, fu, allow, locked;
    logic [8:0] res;
    logic [7:0] rdata;
    logic [5:0] irq, masks;
    logic [1:0] fd, lim;
    int num_errors = 0;
    int n_compared = 0;
    pmicd_regs uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(w_en), .reg_rd_i(r_en), .reg_rdata_o(rdata), .otp_load_i(otp_ld),
        .otp_monitor_masks_i(otp_mask), .otp_step_up_freq_code_i(otp_fu), .otp_step_down_freq_code_i(otp_fd),
        .otp_step_up_current_limit_i(2'h2), .otp_pin_disable_allow_i(1'b1), .otp_single_error_i(otp_single),
        .otp_double_error_i(otp_double), .monitor_edge_event_i(ev), .monitor_irq_set_o(irq),
        .monitor_irq_masks_o(masks), .meas_start_o(start), .meas_buck1_sel_o(b1), .meas_done_i(done),
        .meas_result_i(res), .step_up_freq_code_o(fu), .step_down_freq_code_o(fd),
        .step_up_current_limit_o(lim), .watchdog_config_lock_i(cfg_lock), .pin_disable_allow_o(allow),
        .pin_disable_allow_locked_o(locked));
    pmicd_meas_model #(.DELAY(4), .RES0(RES0), .RES1(RES1)) u_meas (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .start_i(start), .buck1_i(b1), .done_o(done), .result_o(res));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic check(input string n, input logic [8:0] s, input logic [8:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        w_en <= 1'b1;
        @(posedge mclk_i);
        w_en <= 1'b0;
    endtask
    task automatic get(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        addr <= a;
        r_en <= 1'b1;
        @(posedge mclk_i);
        r_en <= 1'b0;
        @(negedge mclk_i);
        check($sformatf("reg %h", a), {1'b0, rdata}, {1'b0, e});
    endtask
    task automatic codes(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        put(pmicd_pkg::ADDR_UNLOCK_CODE, a);
        put(pmicd_pkg::ADDR_UNLOCK_CODE, b);
        put(pmicd_pkg::ADDR_UNLOCK_CODE, c);
    endtask
    task automatic t_reset;
        get(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h02);
        get(pmicd_pkg::ADDR_UNLOCK_CODE, 8'h00);
        get(8'h40, 8'h00);
    endtask
    task automatic t_masks;
        for (int i = 0; i < 6; i++) begin
            put(pmicd_pkg::ADDR_MONITOR_MASKS, 8'h01 << i);
            get(pmicd_pkg::ADDR_MONITOR_MASKS, 8'h01 << i);
            check("masks", {3'h0, masks}, {3'h0, 6'h01 << i});
            @(posedge mclk_i);
            ev <= 6'h3f;
            @(negedge mclk_i);
            check("irq", {3'h0, irq}, {3'h0, 6'h3f & ~(6'h01 << i)});
            @(posedge mclk_i);
            ev <= 6'h00;
        end
    endtask
    task automatic t_otp;
        for (int c = 0; c < 4; c++) begin
            @(posedge mclk_i);
            otp_mask <= 6'h2a;
            otp_fd <= c[1:0];
            otp_fu <= c[0];
            otp_ld <= 1'b1;
            otp_single <= 1'b1;
            @(posedge mclk_i);
            otp_ld <= 1'b0;
            get(pmicd_pkg::ADDR_FREQ_REPORT, {5'h00, c[0], c[1:0]});
        end
        check("freq", {6'h00, fu, fd}, 9'h007);
        get(pmicd_pkg::ADDR_MONITOR_MASKS, 8'h2a);
        get(pmicd_pkg::ADDR_BOOST_LIMIT, 8'h02);
        get(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h03);
        get(pmicd_pkg::ADDR_OTP_STATUS, 8'h01);
        @(posedge mclk_i);
        otp_single <= 1'b0;
        otp_double <= 1'b1;
        get(pmicd_pkg::ADDR_OTP_STATUS, 8'h02);
        put(pmicd_pkg::ADDR_FREQ_REPORT, 8'h00);
        get(pmicd_pkg::ADDR_FREQ_REPORT, 8'h07);
    endtask
    task automatic t_limit;
        for (int c = 0; c < 4; c++) begin
            put(pmicd_pkg::ADDR_BOOST_LIMIT, c[7:0]);
            get(pmicd_pkg::ADDR_BOOST_LIMIT, c[7:0]);
            check("limit", {7'h00, lim}, c[8:0]);
        end
    endtask
    task automatic t_meas;
        logic [8:0] e;
        for (int s = 0; s < 4; s++) begin
            e = s[0] ? RES1 : RES0;
            put(pmicd_pkg::ADDR_LOAD_SELECT, s[7:0]);
            repeat (8) @(posedge mclk_i);
            check("buck", {8'h00, b1}, {8'h00, s[0]});
            get(pmicd_pkg::ADDR_LOAD_HIGH, {7'h00, e[8]});
            get(pmicd_pkg::ADDR_LOAD_LOW, e[7:0]);
        end
    endtask
    task automatic t_unlock;
        put(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h00);
        cfg_lock <= 1'b1;
        codes(8'h87, 8'h65, 8'h1b);
        get(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h02);
        @(posedge mclk_i);
        cfg_lock <= 1'b0;
        codes(8'h87, 8'h00, 8'h1b);
        get(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h02);
        codes(8'h87, 8'h65, 8'h1b);
        get(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h00);
        put(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h01);
        get(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h01);
        check("allow", {7'h00, locked, allow}, 9'h001);
        put(pmicd_pkg::ADDR_UNLOCK_CODE, 8'h55);
        get(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h03);
        put(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h00);
        put(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h01);
        get(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h02);
        codes(8'h87, 8'h65, 8'h1b);
        cfg_lock <= 1'b1;
        @(posedge mclk_i);
        cfg_lock <= 1'b0;
        get(pmicd_pkg::ADDR_PIN_DISABLE_CTRL, 8'h02);
        check("locked", {7'h00, locked, allow}, 9'h002);
    endtask
    task automatic test_done;
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_masks();
        t_otp();
        t_limit();
        t_meas();
        t_unlock();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        num_errors++;
        test_done();
    end
endmodule
`default_nettype wire
